// ==== hdl/mmd_memory_map.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mmd_consts.svh"

module mmd_memory_map #(
  parameter int          CODE_SIZE = 16'h2000,
  parameter logic [15:0] CODE_INIT_FILL = 16'h00FF
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  input  wire logic                acc_req_i,
  input  wire mmd_pkg::mmd_op_t    acc_op_i,
  input  wire logic                acc_we_i,
  input  wire logic [7:0]          acc_addr_i,
  input  wire logic                acc_ptr_sel_i,
  input  wire logic [7:0]          acc_wdata_i,
  input  wire logic                acc_bit_i,
  input  wire logic [7:0]          psw_i,
  input  wire logic                push_i,
  input  wire logic                pop_i,
  input  wire logic [7:0]          push_data_i,
  input  wire logic                code_req_i,
  input  wire logic [15:0]         code_addr_i,
  input  wire logic                code_prog_we_i,
  input  wire logic [15:0]         code_prog_addr_i,
  input  wire logic [7:0]          code_prog_data_i,
  input  wire logic                xmove_req_i,
  input  wire logic                xmove_we_i,
  input  wire logic                xmove_sixteen_bit_data_pointer_i,
  input  wire logic [15:0]         xmove_sixteen_bit_data_pointer_addr_i,
  input  wire logic [7:0]          xmove_wdata_i,
  input  wire logic [7:0]          sfr_rdata_i,
  output logic [7:0]               acc_rdata_o,
  output logic                     acc_rvalid_o,
  output logic [7:0]               sp_o,
  output logic                     page_bit_o,
  output logic [7:0]               sfr_addr_o,
  output logic [7:0]               sfr_wdata_o,
  output logic                     sfr_we_o,
  output logic                     sfr_re_o,
  output logic [7:0]               code_rdata_o,
  output logic                     code_rvalid_o,
  output logic                     code_fault_o,
  output logic [7:0]               xmove_rdata_o,
  output logic                     xmove_rvalid_o
);

  // Constants narrowed once so that no comparison silently resizes them
  localparam int          XRAM_DEPTH      = 1 << `MMD_XRAM_ADDR_W;
  localparam int          CODE_IDX_W      = $clog2(CODE_SIZE);
  localparam logic [15:0] CODE_LIMIT      = CODE_SIZE[15:0];
  localparam logic [15:0] FACTORY_BASE    = `MMD_CODE_FACTORY_BASE;
  localparam logic [15:0] LARGEST_CODE    = `MMD_CODE_SIZE_8K;
  localparam logic [7:0]  LOWER_RAM_TOP   = `MMD_LOWER_RAM_TOP;
  localparam logic [7:0]  BIT_REGION_BASE = `MMD_BIT_REGION_BASE;
  localparam logic [7:0]  PAGE_REG_ADDR   = `MMD_PAGE_REG_ADDR;
  localparam logic [7:0]  PAGE_RESET_BYTE = `MMD_PAGE_REG_RESET;
  localparam logic [7:0]  SP_REG_ADDR     = `MMD_SP_ADDR;
  localparam logic [7:0]  SP_RESET_BYTE   = `MMD_SP_RESET;

  // Internal RAM, external RAM and code store
  logic [7:0] iram [0:255];
  logic [7:0] xram [0:XRAM_DEPTH-1];
  logic [7:0] code_mem [0:CODE_SIZE-1];

  // Every register of the block lives in this one struct
  mmd_pkg::mmd_state_t state_reg;
  mmd_pkg::mmd_state_t state_next;

  // Base address of each of the four register banks
  logic [7:0] bank_base [0:3];

  for (genvar g = 0; g < 4; g++) begin : g_bank
    assign bank_base[g] = 8'(8 * g);
  end

  function automatic logic [1:0] bank_of(input logic [7:0] processor_status_word);
    bank_of = {processor_status_word[`MMD_PSW_BANK_HI_POS], processor_status_word[`MMD_PSW_BANK_LO_POS]};
  endfunction

  function automatic logic [7:0] reg_addr(input logic [7:0] processor_status_word, input logic [2:0] idx);
    reg_addr = bank_base[bank_of(processor_status_word)] | {5'h00, idx};
  endfunction

  function automatic logic is_bit_op(input mmd_pkg::mmd_op_t op);
    is_bit_op = (op == mmd_pkg::MMD_OP_BIT);
  endfunction

  function automatic logic is_sfr_access(input mmd_pkg::mmd_op_t op, input logic [7:0] addr);
    is_sfr_access = (op == mmd_pkg::MMD_OP_DIRECT) && (addr > LOWER_RAM_TOP);
  endfunction

  function automatic logic [7:0] bit_byte_addr(input logic [7:0] baddr);
    bit_byte_addr = BIT_REGION_BASE + {4'h0, baddr[6:3]};
  endfunction

  function automatic logic [7:0] insert_bit(input logic [7:0] old_byte,
                                           input logic [2:0] pos, input logic val);
    insert_bit      = old_byte;
    insert_bit[pos] = val;
  endfunction

  function automatic logic [7:0] page_read_byte(input logic page);
    page_read_byte = {7'h00, page};
  endfunction

  function automatic logic [8:0] xram_index(input logic sixteen_bit_data_pointer, input logic [15:0] addr,
                                           input logic page);
    if (sixteen_bit_data_pointer) begin
      xram_index = addr[8:0];
    end else begin
      xram_index = {page, addr[7:0]};
    end
  endfunction

  function automatic logic code_user_ok(input logic [15:0] addr);
    code_user_ok = (addr < CODE_LIMIT) &&
                   !((CODE_LIMIT == LARGEST_CODE) && (addr >= FACTORY_BASE));
  endfunction

  logic [7:0] ptr_addr;
  logic [7:0] eff_addr;
  logic       to_sfr;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic [7:0] ram_wbyte;
  logic       ram_we;
  logic [8:0] xaddr;
  logic       code_ok;
  logic [7:0] push_addr;
  logic [7:0] pop_addr;
  logic [7:0] stack_top;
  logic [7:0] local_sfr_rbyte;
  logic       acc_read;
  logic       acc_write;
  logic       acc_to_ram;
  logic       push_taken;
  logic       pop_taken;
  logic       iram_we;
  logic [7:0] iram_waddr;
  logic [7:0] iram_wdata;
  logic       xram_we;
  logic       code_we;
  logic [CODE_IDX_W-1:0] code_widx;
  logic [CODE_IDX_W-1:0] code_ridx;

  // Address decode for internal data accesses
  always_comb begin
    ptr_addr  = iram[reg_addr(psw_i, {2'h0, acc_ptr_sel_i})];
    bit_byte  = bit_byte_addr(acc_addr_i);
    bit_pos   = acc_addr_i[2:0];
    to_sfr    = 1'b0;
    eff_addr  = acc_addr_i;
    case (acc_op_i)
      mmd_pkg::MMD_OP_DIRECT: begin
        to_sfr = is_sfr_access(acc_op_i, acc_addr_i);
      end
      mmd_pkg::MMD_OP_INDIRECT: begin
        eff_addr = acc_addr_i;
      end
      mmd_pkg::MMD_OP_BIT: begin
        eff_addr = bit_byte;
      end
      mmd_pkg::MMD_OP_REG: begin
        eff_addr = reg_addr(psw_i, acc_addr_i[2:0]);
      end
      mmd_pkg::MMD_OP_PTR_IND: begin
        eff_addr = ptr_addr;
      end
      default: begin
        eff_addr = acc_addr_i;
      end
    endcase
    ram_wbyte = acc_wdata_i;
    if (is_bit_op(acc_op_i)) begin
      ram_wbyte = insert_bit(iram[eff_addr], bit_pos, acc_bit_i);
    end
    ram_we  = acc_write && acc_to_ram;
    xaddr   = xram_index(xmove_sixteen_bit_data_pointer_i, xmove_sixteen_bit_data_pointer_addr_i, state_reg.page);
    code_ok = code_user_ok(code_addr_i);
  end

  // Request qualifiers; a data access blocks push and pop
  always_comb begin
    acc_read   = acc_req_i && !acc_we_i;
    acc_write  = acc_req_i && acc_we_i;
    acc_to_ram = acc_req_i && !to_sfr;
    push_taken = push_i && !acc_req_i;
    pop_taken  = pop_i && !acc_req_i;
  end

  // Stack pointer steps wrap within the 256-byte internal RAM
  always_comb begin
    push_addr = state_reg.sp + 8'h01;
    pop_addr  = state_reg.sp - 8'h01;
    stack_top = iram[state_reg.sp];
  end

  // Locally held special registers answer here, the rest come from outside
  always_comb begin
    local_sfr_rbyte = sfr_rdata_i;
    if (acc_addr_i == PAGE_REG_ADDR) begin
      local_sfr_rbyte = page_read_byte(state_reg.page);
    end else if (acc_addr_i == SP_REG_ADDR) begin
      local_sfr_rbyte = state_reg.sp;
    end
  end

  // Next state of all registered outputs
  always_comb begin
    state_next            = state_reg;
    state_next.rvalid     = 1'b0;
    state_next.sfr_we     = 1'b0;
    state_next.sfr_re     = 1'b0;
    state_next.code_valid = 1'b0;
    state_next.xvalid     = 1'b0;
    state_next.st         = mmd_pkg::MMD_ST_IDLE;
    if (acc_req_i) begin
      if (to_sfr) begin
        state_next.sfr_addr  = acc_addr_i;
        state_next.sfr_wdata = acc_wdata_i;
        state_next.sfr_we    = acc_we_i;
        state_next.sfr_re    = !acc_we_i;
        if (acc_we_i && (acc_addr_i == PAGE_REG_ADDR)) begin
          state_next.page = acc_wdata_i[`MMD_PAGE_BIT_POS];
        end
        if (acc_we_i && (acc_addr_i == SP_REG_ADDR)) begin
          state_next.sp = acc_wdata_i;
        end
        state_next.rdata = local_sfr_rbyte;
      end else if (is_bit_op(acc_op_i)) begin
        state_next.rdata = {7'h00, iram[eff_addr][bit_pos]};
      end else begin
        state_next.rdata = iram[eff_addr];
      end
      state_next.rvalid = !acc_we_i;
    end else if (push_taken) begin
      state_next.sp        = push_addr;
      state_next.push_byte = push_data_i;
      state_next.st        = mmd_pkg::MMD_ST_PUSH;
    end else if (pop_taken) begin
      state_next.rdata  = stack_top;
      state_next.rvalid = 1'b1;
      state_next.sp     = pop_addr;
      state_next.st     = mmd_pkg::MMD_ST_POP;
    end
    if (code_req_i) begin
      state_next.code_data  = code_ok ? code_mem[code_ridx] : 8'h00;
      state_next.code_valid = 1'b1;
      state_next.code_fault = !code_ok;
    end
    if (xmove_req_i) begin
      state_next.xdata  = xram[xaddr];
      state_next.xvalid = !xmove_we_i;
    end
  end

  // Registered state with asynchronous reset
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg            <= '0;
      state_reg.sp         <= SP_RESET_BYTE;
      state_reg.page       <= PAGE_RESET_BYTE[`MMD_PAGE_BIT_POS];
      state_reg.st         <= mmd_pkg::MMD_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Write ports of the three memories
  always_comb begin
    iram_we    = 1'b0;
    iram_waddr = eff_addr;
    iram_wdata = ram_wbyte;
    if (ram_we) begin
      iram_we = 1'b1;
    end else if (push_taken) begin
      iram_we    = 1'b1;
      iram_waddr = push_addr;
      iram_wdata = push_data_i;
    end
    xram_we   = xmove_req_i && xmove_we_i;
    code_we   = code_prog_we_i && (code_prog_addr_i < CODE_LIMIT);
    code_widx = code_prog_addr_i[CODE_IDX_W-1:0];
    code_ridx = code_addr_i[CODE_IDX_W-1:0];
  end

  // Memories have no reset; their contents start undefined
  always_ff @(posedge clk_sys_i) begin
    if (iram_we) begin
      iram[iram_waddr] <= iram_wdata;
    end
    if (xram_we) begin
      xram[xaddr] <= xmove_wdata_i;
    end
    if (code_we) begin
      code_mem[code_widx] <= code_prog_data_i;
    end
  end

  // Outputs come straight from the state register
  always_comb begin
    acc_rdata_o    = state_reg.rdata;
    acc_rvalid_o   = state_reg.rvalid;
    sp_o           = state_reg.sp;
    page_bit_o     = state_reg.page;
    sfr_addr_o     = state_reg.sfr_addr;
    sfr_wdata_o    = state_reg.sfr_wdata;
    sfr_we_o       = state_reg.sfr_we;
    sfr_re_o       = state_reg.sfr_re;
    code_rdata_o   = state_reg.code_data;
    code_rvalid_o  = state_reg.code_valid;
    code_fault_o   = state_reg.code_fault;
    xmove_rdata_o  = state_reg.xdata;
    xmove_rvalid_o = state_reg.xvalid;
  end

endmodule
`default_nettype wire

// ==== inc/mmd_consts.svh ====
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

`define MMD_CODE_SIZE_8K      16'h2000
`define MMD_CODE_SIZE_4K      16'h1000
`define MMD_CODE_SIZE_2K      16'h0800
`define MMD_CODE_FACTORY_BASE 16'h1E00
`define MMD_LOWER_RAM_TOP     8'h7F
`define MMD_BIT_REGION_BASE   8'h20
`define MMD_PAGE_REG_ADDR     8'hAA
`define MMD_PAGE_REG_RESET    8'h00
`define MMD_PAGE_BIT_POS      0
`define MMD_SP_ADDR           8'h81
`define MMD_SP_RESET          8'h07
`define MMD_PSW_BANK_LO_POS   3
`define MMD_PSW_BANK_HI_POS   4
`define MMD_XRAM_ADDR_W       9

`endif

// ==== inc/mmd_pkg.sv ====
package mmd_pkg;

  typedef enum logic [2:0] {
    MMD_ST_IDLE  = 3'b001,
    MMD_ST_PUSH  = 3'b010,
    MMD_ST_POP   = 3'b100
  } mmd_stack_st_t;

  typedef enum logic [2:0] {
    MMD_OP_DIRECT   = 3'h0,
    MMD_OP_INDIRECT = 3'h1,
    MMD_OP_BIT      = 3'h2,
    MMD_OP_REG      = 3'h3,
    MMD_OP_PTR_IND  = 3'h4
  } mmd_op_t;

  typedef struct packed {
    logic [7:0]    sp;
    logic          page;
    mmd_stack_st_t st;
    logic [7:0]    rdata;
    logic          rvalid;
    logic [7:0]    sfr_addr;
    logic [7:0]    sfr_wdata;
    logic          sfr_we;
    logic          sfr_re;
    logic [7:0]    code_data;
    logic          code_valid;
    logic          code_fault;
    logic [7:0]    xdata;
    logic          xvalid;
    logic [7:0]    push_byte;
  } mmd_state_t;

endpackage

// ==== test/mmd_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmd_sva #(
  parameter int CODE_SIZE = 16'h2000
) (
  input wire logic             clk_sys_i,
  input wire logic             rstn_i,
  input wire logic             acc_req_i,
  input wire logic             acc_we_i,
  input wire mmd_pkg::mmd_op_t acc_op_i,
  input wire logic [7:0]       acc_addr_i,
  input wire logic [7:0]       acc_wdata_i,
  input wire logic             push_i,
  input wire logic             code_req_i,
  input wire logic [15:0]      code_addr_i,
  input wire logic             xmove_req_i,
  input wire logic             xmove_we_i,
  input wire logic             acc_rvalid_o,
  input wire logic [7:0]       sp_o,
  input wire logic             page_bit_o,
  input wire logic             sfr_we_o,
  input wire logic             code_rvalid_o,
  input wire logic             code_fault_o,
  input wire logic             xmove_rvalid_o
);
  localparam int LIM = CODE_SIZE == 8192 ? 16'h1E00 : CODE_SIZE;
  wire dir = acc_req_i && acc_op_i == mmd_pkg::MMD_OP_DIRECT;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  property p_rd; acc_req_i && !acc_we_i |=> acc_rvalid_o; endproperty
  a_rd: assert property (p_rd) else $error("read unanswered");
  property p_sfr; dir |=> sfr_we_o == ($past(acc_we_i) && $past(acc_addr_i) > 8'h7F);
  endproperty
  a_sfr: assert property (p_sfr) else $error("sfr routing wrong");
  property p_push; push_i && !acc_req_i |=> sp_o == $past(sp_o) + 8'h01; endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");
  property p_spw; dir && acc_we_i && acc_addr_i == 8'h81 |=> sp_o == $past(acc_wdata_i);
  endproperty
  a_spw: assert property (p_spw) else $error("pointer write lost");
  property p_cf; code_req_i && code_addr_i >= LIM |=> code_rvalid_o && code_fault_o;
  endproperty
  a_cf: assert property (p_cf) else $error("factory code read");
  property p_ck; code_req_i && code_addr_i < LIM |=> code_rvalid_o && !code_fault_o;
  endproperty
  a_ck: assert property (p_ck) else $error("user code refused");
  property p_pg; dir && acc_we_i && acc_addr_i == 8'hAA
    |=> page_bit_o == |($past(acc_wdata_i) & 8'h01); endproperty
  a_pg: assert property (p_pg) else $error("page bit wrong");
  property p_xr; xmove_req_i && !xmove_we_i |=> xmove_rvalid_o; endproperty
  a_xr: assert property (p_xr) else $error("xram read unanswered");
  c_fault: cover property (code_req_i && code_addr_i >= LIM);
  c_wrap: cover property (push_i && sp_o == 8'hFF);
  c_page: cover property (xmove_req_i && page_bit_o);
endmodule
`default_nettype wire

// ==== test/mmd_sfr_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mmd_sfr_model (
  input  wire logic [7:0] addr_i,
  output logic [7:0]      rdata_o
);
  // Peripheral byte differs from its address so stale data shows
  assign rdata_o = addr_i ^ 8'h5A;
endmodule
`default_nettype wire

// ==== test/memory_map_decode_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module memory_map_decode_tb;
  localparam logic [15:0] CA [4] = '{16'h0000, 16'h1DFF, 16'h1E00, 16'h1FFF};
  logic clk_sys_i, rstn_i, acc_req_i, acc_we_i, acc_ptr_sel_i, acc_bit_i, push_i, pop_i;
  logic code_req_i, code_prog_we_i, xmove_req_i, xmove_we_i, xmove_sixteen_bit_data_pointer_i, acc_rvalid_o;
  logic page_bit_o, sfr_we_o, sfr_re_o, code_rvalid_o, code_fault_o, xmove_rvalid_o;
  logic [7:0] acc_addr_i, acc_wdata_i, psw_i, push_data_i, xmove_wdata_i, sfr_rdata_i;
  logic [7:0] code_prog_data_i, acc_rdata_o, sp_o, sfr_addr_o, sfr_wdata_o;
  logic [7:0] code_rdata_o, xmove_rdata_o;
  logic [15:0] code_addr_i, code_prog_addr_i, xmove_sixteen_bit_data_pointer_addr_i;
  mmd_pkg::mmd_op_t acc_op_i;
  int fails, n_checks, im[256], xm[512], sp, a, b;
  mmd_memory_map dut (.*);
  mmd_sfr_model sfr (.addr_i(acc_addr_i), .rdata_o(sfr_rdata_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic st(ref logic s);
    @(negedge clk_sys_i);
    s = 1'b1;
    @(negedge clk_sys_i);
    s = 1'b0;
  endtask
  task automatic acc(mmd_pkg::mmd_op_t o, logic w, logic [7:0] ad, logic [7:0] d);
    acc_op_i = o;
    acc_we_i = w;
    acc_addr_i = ad;
    acc_wdata_i = d;
    st(acc_req_i);
  endtask
  task automatic rd(mmd_pkg::mmd_op_t o, logic [7:0] ad, logic [7:0] e);
    acc(o, 1'b0, ad, 8'h00);
    chk("acc_rdata_o", {acc_rvalid_o, acc_rdata_o}, {1'b1, e});
  endtask
  task automatic complete_run();
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {rstn_i, acc_req_i, acc_we_i, acc_ptr_sel_i, acc_bit_i, push_i, pop_i, code_req_i} = '0;
    {code_prog_we_i, xmove_req_i, xmove_we_i, xmove_sixteen_bit_data_pointer_i, acc_addr_i, acc_wdata_i} = '0;
    {psw_i, push_data_i, xmove_wdata_i, code_prog_data_i, code_addr_i} = '0;
    {code_prog_addr_i, xmove_sixteen_bit_data_pointer_addr_i, fails, n_checks} = '0;
    acc_op_i = mmd_pkg::MMD_OP_DIRECT;
    void'($urandom(74051));
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rstn_i = 1'b1;
    chk("sp_o", sp_o, 8'h07);
    chk("page_bit_o", page_bit_o, 1'b0);
    for (a = 0; a < 256; a++) begin
      im[a] = $urandom % 256;
      acc(mmd_pkg::MMD_OP_INDIRECT, 1'b1, a[7:0], im[a][7:0]);
    end
    for (a = 0; a < 256; a++)
      rd(a[7] ? mmd_pkg::MMD_OP_INDIRECT : mmd_pkg::MMD_OP_DIRECT, a[7:0], im[a][7:0]);
    rd(mmd_pkg::MMD_OP_DIRECT, 8'h90, 8'hCA);
    chk("sfr_rd", {sfr_re_o, sfr_we_o, sfr_addr_o}, {2'b10, 8'h90});
    for (b = 0; b < 4; b++) begin
      psw_i = 8'hE7 | 8'(b << 3);
      im[8 * b] = 8'h30 + b;
      im[8 * b + 1] = 8'h40 + b;
      acc(mmd_pkg::MMD_OP_REG, 1'b1, 8'h00, im[8 * b][7:0]);
      acc(mmd_pkg::MMD_OP_REG, 1'b1, 8'h01, im[8 * b + 1][7:0]);
      rd(mmd_pkg::MMD_OP_INDIRECT, 8'(8 * b), im[8 * b][7:0]);
      acc_ptr_sel_i = b[0];
      rd(mmd_pkg::MMD_OP_PTR_IND, 8'h00, im[im[8 * b + b % 2]][7:0]);
    end
    repeat (8) begin
      a = $urandom % 128;
      b = 8'h20 + a / 8;
      acc_bit_i = !im[b][a % 8];
      im[b][a % 8] = acc_bit_i;
      acc(mmd_pkg::MMD_OP_BIT, 1'b1, a[7:0], 8'($urandom));
      rd(mmd_pkg::MMD_OP_DIRECT, b[7:0], im[b][7:0]);
    end
    sp = 7;
    for (a = 0; a < 4; a++) begin
      if (a == 1) begin
        sp = 8'hFE;
        acc(mmd_pkg::MMD_OP_DIRECT, 1'b1, 8'h81, 8'hFE);
      end
      sp = (sp + 1) % 256;
      im[sp] = $urandom % 256;
      push_data_i = im[sp][7:0];
      st(push_i);
      chk("sp_o", sp_o, sp[7:0]);
    end
    rd(mmd_pkg::MMD_OP_DIRECT, 8'h08, im[8][7:0]);
    repeat (4) begin
      st(pop_i);
      chk("pop", {acc_rvalid_o, acc_rdata_o}, {1'b1, im[sp][7:0]});
      sp = (sp + 255) % 256;
    end
    chk("sp_o", sp_o, sp[7:0]);
    for (a = 0; a < 4; a++) begin
      b = a < 2 ? $urandom % 256 : 0;
      code_prog_addr_i = CA[a];
      code_prog_data_i = b[7:0];
      code_addr_i = CA[a];
      if (a < 2) st(code_prog_we_i);
      st(code_req_i);
      chk("code", {code_rvalid_o, code_fault_o, code_rdata_o}, {1'b1, a > 1, b[7:0]});
    end
    acc(mmd_pkg::MMD_OP_DIRECT, 1'b1, 8'hAA, 8'hFF);
    chk("sfr_wr", {sfr_we_o, sfr_wdata_o}, {1'b1, 8'hFF});
    rd(mmd_pkg::MMD_OP_DIRECT, 8'hAA, 8'h01);
    @(negedge clk_sys_i);
    rstn_i = 1'b0;
    @(negedge clk_sys_i);
    rstn_i = 1'b1;
    chk("reset", {sp_o, 7'h00, page_bit_o}, {8'h07, 7'h00, 1'b0});
    for (b = 1; b >= 0; b--) begin
      acc(mmd_pkg::MMD_OP_DIRECT, 1'b1, 8'hAA, 8'(8'hFE | b));
      chk("page_bit_o", page_bit_o, b[0]);
      repeat (3) begin
        a = $urandom & 16'hFEFF | b << 8;
        xm[a % 512] = $urandom % 256;
        {xmove_we_i, xmove_sixteen_bit_data_pointer_i, xmove_sixteen_bit_data_pointer_addr_i} = {2'b11, a[15:0]};
        xmove_wdata_i = xm[a % 512][7:0];
        st(xmove_req_i);
        {xmove_we_i, xmove_sixteen_bit_data_pointer_i, xmove_sixteen_bit_data_pointer_addr_i} = {2'b00, a[15:0] ^ 16'hFF00};
        st(xmove_req_i);
        chk("xmove8", {xmove_rvalid_o, xmove_rdata_o}, {1'b1, xm[a % 512][7:0]});
        {xmove_sixteen_bit_data_pointer_i, xmove_sixteen_bit_data_pointer_addr_i} = {1'b1, a[15:0] ^ 16'hFE00};
        st(xmove_req_i);
        chk("xmove16", {xmove_rvalid_o, xmove_rdata_o}, {1'b1, xm[a % 512][7:0]});
      end
    end
    complete_run();
  end
  initial begin
    #500000;
    fails++;
    complete_run();
  end
endmodule
bind mmd_memory_map mmd_sva #(.CODE_SIZE(CODE_SIZE)) u_sva (.*);
`default_nettype wire
